/* File: logic/gatl_pkg.sv */
// package: constants and types of the gas alarm threshold logic
package gatl_pkg;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INHIBIT_S = 60;
   localparam int INHIBIT_MS = INHIBIT_S * 1000;
   localparam int IDLE_S = 300;
   localparam int IDLE_MS = IDLE_S * 1000;
   // ************************************************************
   // levels
   // ************************************************************
   localparam int SET_MAX_PCT = 70;
   localparam int HYST_PCT = 10;
   localparam int PCT_FULL = 100;
   localparam int SET_MIN = 1;
   localparam int FULL_SCALE_DEF = 1000;
   localparam int THR1_RST_DEF = 100;
   localparam int THR2_RST_DEF = 200;
   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_FAULT = 8'h08;
   localparam logic [7:0] REG_SET1 = 8'h0C;
   localparam logic [7:0] REG_SET2 = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;
   localparam int CTRL_FIT = 2;
   localparam int FLT_ADAPTER = 0;
   localparam int FLT_BOARD = 1;
   localparam int FLT_ZERO = 2;
   localparam int FLT_CAL = 3;
   localparam int BTN_MENU = 2;
   localparam int BTN_INC = 1;
   localparam int BTN_DEC = 0;
   typedef enum logic [2:0] {SCR_NORMAL, SCR_THR1, SCR_DIR1, SCR_THR2, SCR_DIR2} gatl_screen_t;
endpackage

/* File: logic/gatl_chan_if.sv */
`timescale 1ns/100ps
// interface: one alarm channel between menu logic and its evaluator
interface gatl_chan_if #(parameter int W = 16);
   logic [W-1:0] conc;
   logic [W-1:0] thr;
   logic dir_fall;
   logic latch;
   logic man_reset;
   logic inhibit;
   logic active;
   modport ctrl (output conc, thr, dir_fall, latch, man_reset, inhibit, input active);
   modport chan (input conc, thr, dir_fall, latch, man_reset, inhibit, output active);
endinterface

/* File: logic/gatl_alarm_chan.sv */
`timescale 1ns/100ps
// module: evaluator of one alarm level with hysteresis and latching
module gatl_alarm_chan
   import gatl_pkg::*;
#(
   parameter int W = 16
)(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   gatl_chan_if.chan bus
);
   localparam int W1 = W + 1;
   typedef struct packed {
      logic active;
      logic pend;
   } gatl_chan_st_t;
   gatl_chan_st_t st, next_st;
   logic [W:0] hyst;
   logic trig;
   logic clr_ok;
   always_comb begin
      hyst = W1'((32'(bus.thr) * HYST_PCT) / PCT_FULL);
      trig = bus.dir_fall ? (bus.conc <= bus.thr) : (bus.conc >= bus.thr);
      if (bus.dir_fall) begin
         clr_ok = {1'b0, bus.conc} > ({1'b0, bus.thr} + hyst);
      end else begin
         clr_ok = {1'b0, bus.conc} < ({1'b0, bus.thr} - hyst);
      end
      next_st = st;
      if (!st.active) begin
         next_st.active = trig && !bus.inhibit;
         next_st.pend = 1'b0;
      end else if (bus.latch) begin
         // a reset asked while gas is still present waits for it to go
         if ((st.pend || bus.man_reset) && !trig) begin
            next_st.active = 1'b0;
            next_st.pend = 1'b0;
         end else if (bus.man_reset) begin
            next_st.pend = 1'b1;
         end
      end else if (clr_ok) begin
         next_st.active = 1'b0;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end
   assign bus.active = st.active;
   // ************************************************************
   // checks
   // ************************************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_rise_trig: assert property (ce && !st.active && !bus.inhibit && !bus.dir_fall && bus.conc >= bus.thr
      |=> st.active) else $error("rising alarm missed");
   a_fall_trig: assert property (ce && !st.active && !bus.inhibit && bus.dir_fall && bus.conc <= bus.thr
      |=> st.active) else $error("falling alarm missed");
   a_inhibit_hold: assert property (ce && !st.active && bus.inhibit |=> !st.active)
      else $error("alarm rose while inhibited");
   a_latch_hold: assert property (ce && st.active && bus.latch && trig |=> st.active)
      else $error("latched alarm dropped with gas present");
   a_auto_hold: assert property (ce && st.active && !bus.latch && !clr_ok |=> st.active)
      else $error("auto alarm dropped inside hysteresis");
endmodule

/* File: logic/gatl_top.sv */
`timescale 1ns/100ps
// module: two-level gas alarm evaluator with menu, faults and registers
//
// Contract
// - two set-points, step one up to seventy percent
// - alarms evaluated whether or not relays fitted
// - per-alarm rising or falling, resets to rising
// - at or above first set-point lights amber
// - at or above second set-point lights red
// - alarm clears by hysteresis or manual reset
// - fitted relays follow their alarms
// - no alarm rise for a minute after menu
// - threshold screen: up, down, menu stores
// - direction screen: up rising, down falling
// - screens in fixed order, last returns normal
// - flag lost sensor adapter link
// - flag lost sensor board link
// - flag failed zeroing
// - flag failed calibration
// - any fault drives fault terminal
// - five idle minutes leave the menu
module gatl_top
   import gatl_pkg::*;
#(
   parameter int CONC_W = 16,
   parameter int FULL_SCALE = FULL_SCALE_DEF,
   parameter int THR1_RST = THR1_RST_DEF,
   parameter int THR2_RST = THR2_RST_DEF,
   parameter int TICK_CYC_P = TICK_CYC,
   parameter int INHIBIT_MS_P = INHIBIT_MS,
   parameter int IDLE_MS_P = IDLE_MS
)(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [CONC_W-1:0] conc,
   input wire logic btn_menu,
   input wire logic btn_inc,
   input wire logic btn_dec,
   input wire logic adapter_link_down,
   input wire logic board_link_down,
   input wire logic zero_fail,
   input wire logic cal_fail,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic led_amber,
   output logic led_red,
   output logic relay1,
   output logic relay2,
   output logic fault_terminal
);
   // ************************************************************
   // sizes and limits
   // ************************************************************
   localparam int W = CONC_W;
   localparam int TW = $clog2(TICK_CYC_P + 1);
   localparam int IW = $clog2(IDLE_MS_P + 1);
   localparam int HW = $clog2(INHIBIT_MS_P + 1);
   localparam int SET_MAX_I = (FULL_SCALE * SET_MAX_PCT) / PCT_FULL;
   localparam logic [W-1:0] SET_MAX = W'(SET_MAX_I);
   localparam logic [W-1:0] SET_LO = W'(SET_MIN);
   localparam logic [W-1:0] THR1_R = W'(THR1_RST);
   localparam logic [W-1:0] THR2_R = W'(THR2_RST);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC_P - 1);
   localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_MS_P - 1);
   localparam logic [HW-1:0] INH_LOAD = HW'(INHIBIT_MS_P);

   if (W < 8 || W > 24) begin : g_chk_w
      $error("CONC_W must be 8 to 24");
   end
   if (FULL_SCALE < 2 || FULL_SCALE >= (1 << W)) begin : g_chk_fs
      $error("FULL_SCALE out of range");
   end
   if (SET_MAX_I < SET_MIN) begin : g_chk_max
      $error("set-point span empty");
   end
   if (THR1_RST < SET_MIN || THR1_RST > SET_MAX_I || THR2_RST < SET_MIN || THR2_RST > SET_MAX_I) begin : g_chk_rst
      $error("reset set-points out of span");
   end
   if (TICK_CYC_P < 1 || INHIBIT_MS_P < 1 || IDLE_MS_P < 1) begin : g_chk_cnt
      $error("timing counts must be at least one");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [2:0] btn_s1;
      logic [2:0] btn_s2;
      logic [2:0] btn_prev;
      logic [1:0] link_s1;
      logic [1:0] link_s2;
      gatl_screen_t scr;
      logic [1:0][W-1:0] thr;
      logic [1:0] dir;
      logic [W-1:0] edit;
      logic edit_dir;
      logic [TW-1:0] tick;
      logic [IW-1:0] idle;
      logic [HW-1:0] inh;
      logic [2:0] ctrl;
      logic [1:0] rst_req;
      logic [3:0] flt;
      logic [31:0] rdata;
      logic amber;
      logic red;
      logic rel1;
      logic rel2;
      logic fterm;
   } gatl_top_st_t;

   gatl_top_st_t st, next_st;
   logic [2:0] press;
   logic tick_hit;
   logic timeout;
   logic sel;
   logic inhibit;
   logic [1:0] act;
   logic [3:0] flt_set;
   logic [3:0] flt_clr;

   // ************************************************************
   // alarm channels
   // ************************************************************
   gatl_chan_if #(.W(W)) chan_bus [2] ();

   for (genvar g = 0; g < 2; g++) begin : g_chan
      assign chan_bus[g].conc = conc;
      assign chan_bus[g].thr = st.thr[g];
      assign chan_bus[g].dir_fall = st.dir[g];
      assign chan_bus[g].latch = st.ctrl[g];
      assign chan_bus[g].man_reset = st.rst_req[g];
      assign chan_bus[g].inhibit = inhibit;
      assign act[g] = chan_bus[g].active;
      gatl_alarm_chan #(
         .W(W)
      ) u_chan (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .ce(ce),
         .bus(chan_bus[g])
      );
   end

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_st = st;
      // buttons have no debounce here; the pins are expected clean
      press = st.btn_s2 & ~st.btn_prev;
      tick_hit = (st.tick == TICK_LAST);
      timeout = tick_hit && (st.idle == IDLE_LAST);
      sel = (st.scr == SCR_THR2) || (st.scr == SCR_DIR2);
      inhibit = (st.scr != SCR_NORMAL) || (st.inh != '0);
      next_st.btn_s1 = {btn_menu, btn_inc, btn_dec};
      next_st.btn_s2 = st.btn_s1;
      next_st.btn_prev = st.btn_s2;
      next_st.link_s1 = {board_link_down, adapter_link_down};
      next_st.link_s2 = st.link_s1;
      next_st.tick = tick_hit ? '0 : st.tick + 1'b1;

      // inhibit keeps counting down in normal operation only
      if (tick_hit && st.inh != '0 && st.scr == SCR_NORMAL) begin
         next_st.inh = st.inh - 1'b1;
      end

      if (press != 3'h0) begin
         next_st.idle = '0;
      end else if (tick_hit) begin
         next_st.idle = st.idle + 1'b1;
      end

      case (st.scr)
         SCR_NORMAL: begin
            next_st.idle = '0;
            if (press[BTN_MENU]) begin
               next_st.scr = SCR_THR1;
               next_st.edit = st.thr[0];
            end
         end
         SCR_THR1, SCR_THR2: begin
            if (press[BTN_MENU]) begin
               next_st.thr[sel] = st.edit;
               next_st.edit_dir = st.dir[sel];
               next_st.scr = sel ? SCR_DIR2 : SCR_DIR1;
            end else if (press[BTN_INC]) begin
               if (st.edit < SET_MAX) begin
                  next_st.edit = st.edit + 1'b1;
               end
            end else if (press[BTN_DEC]) begin
               if (st.edit > SET_LO) begin
                  next_st.edit = st.edit - 1'b1;
               end
            end
         end
         SCR_DIR1, SCR_DIR2: begin
            if (press[BTN_MENU]) begin
               next_st.dir[sel] = st.edit_dir;
               if (sel) begin
                  next_st.scr = SCR_NORMAL;
                  next_st.inh = INH_LOAD;
               end else begin
                  next_st.scr = SCR_THR2;
                  next_st.edit = st.thr[1];
               end
            end else if (press[BTN_INC]) begin
               next_st.edit_dir = 1'b0;
            end else if (press[BTN_DEC]) begin
               next_st.edit_dir = 1'b1;
            end
         end
         default: begin
            next_st.scr = SCR_NORMAL;
         end
      endcase

      // an idle timeout drops the screen being edited unsaved
      if (st.scr != SCR_NORMAL && timeout && press == 3'h0) begin
         next_st.scr = SCR_NORMAL;
         next_st.inh = INH_LOAD;
      end

      // ************************************************************
      // register writes
      // ************************************************************
      next_st.rst_req = 2'h0;
      flt_clr = 4'h0;
      if (reg_wr) begin
         case (reg_addr)
            REG_CTRL: begin
               next_st.ctrl = reg_wdata[2:0];
            end
            REG_CMD: begin
               next_st.rst_req = reg_wdata[1:0];
            end
            REG_FAULT: begin
               flt_clr = reg_wdata[3:0];
            end
            default: begin
               next_st.rst_req = 2'h0;
            end
         endcase
      end

      // set wins over a clear in the same cycle; a lost link keeps its flag up
      flt_set[FLT_ADAPTER] = st.link_s2[0];
      flt_set[FLT_BOARD] = st.link_s2[1];
      flt_set[FLT_ZERO] = zero_fail;
      flt_set[FLT_CAL] = cal_fail;
      next_st.flt = (st.flt & ~flt_clr) | flt_set;
      next_st.fterm = |next_st.flt;

      // ************************************************************
      // indicators and relays
      // ************************************************************
      next_st.amber = act[0];
      next_st.red = act[1];
      next_st.rel1 = act[0] && st.ctrl[CTRL_FIT];
      next_st.rel2 = act[1] && st.ctrl[CTRL_FIT];

      // ************************************************************
      // register reads
      // ************************************************************
      next_st.rdata = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL: begin
               next_st.rdata = {29'h0, st.ctrl};
            end
            REG_FAULT: begin
               next_st.rdata = {28'h0, st.flt};
            end
            REG_SET1: begin
               next_st.rdata = 32'(st.thr[0]);
            end
            REG_SET2: begin
               next_st.rdata = 32'(st.thr[1]);
            end
            REG_STAT: begin
               next_st.rdata = {24'h0, st.scr, inhibit, st.dir, act};
            end
            default: begin
               next_st.rdata = 32'h0;
            end
         endcase
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.thr <= {THR2_R, THR1_R};
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign led_amber = st.amber;
   assign led_red = st.red;
   assign relay1 = st.rel1;
   assign relay2 = st.rel2;
   assign fault_terminal = st.fterm;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_relay_follow: assert property (ce && st.ctrl[CTRL_FIT] |=> relay1 == led_amber && relay2 == led_red)
      else $error("relay not following alarm");
   a_relay_off: assert property (ce && !st.ctrl[CTRL_FIT] |=> !relay1 && !relay2)
      else $error("relay driven while not fitted");
   a_fault_term: assert property (ce && zero_fail |=> fault_terminal && st.flt[FLT_ZERO])
      else $error("zero fault not on terminal");
   a_fault_setwin: assert property (ce && cal_fail && reg_wr && reg_addr == REG_FAULT && reg_wdata[FLT_CAL]
      |=> st.flt[FLT_CAL]) else $error("fault lost under clear");
   a_link_flag: assert property (ce && st.link_s2[1] |=> st.flt[FLT_BOARD] && fault_terminal)
      else $error("board link fault missing");
   a_menu_order: assert property (ce && st.scr == SCR_THR1 && press[BTN_MENU] |=> st.scr == SCR_DIR1)
      else $error("screen order broken");
   a_exit_inhibit: assert property (ce && st.scr == SCR_DIR2 && press[BTN_MENU]
      |=> st.scr == SCR_NORMAL && st.inh == INH_LOAD && inhibit) else $error("no inhibit after menu");
   a_set_range: assert property (st.thr[0] <= SET_MAX && st.thr[0] >= SET_LO && st.thr[1] <= SET_MAX)
      else $error("set-point out of span");
   a_dir_select: assert property (ce && st.scr == SCR_DIR1 && press == 3'h1 |=> st.edit_dir)
      else $error("down did not pick falling");
   a_read_once: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its slot");
endmodule

/* File: verif/gatl_sensor_model.sv */
`timescale 1ns/100ps
// partner model: sensor readout board, fault sources and operator push-buttons
module gatl_sensor_model
   import gatl_pkg::*;
(
   input wire logic clk_sys,
   output logic [15:0] conc,
   output logic btn_menu,
   output logic btn_inc,
   output logic btn_dec,
   output logic adapter_link_down,
   output logic board_link_down,
   output logic zero_fail,
   output logic cal_fail
);
   // ************************************************************
   // fault sources, one bit per fault position
   // ************************************************************
   logic [3:0] flt;
   assign {cal_fail, zero_fail, board_link_down, adapter_link_down} = flt;
   initial begin
      conc = 16'h0000;
      flt = 4'h0;
      {btn_menu, btn_inc, btn_dec} = 3'h0;
   end
   // ************************************************************
   // stimulus tasks, all changes right after a rising edge
   // ************************************************************
   task automatic set_conc(input logic [15:0] v);
      @(posedge clk_sys);
      conc <= v;
   endtask
   task automatic fault(input int idx, input logic v);
      @(posedge clk_sys);
      flt[idx] <= v;
   endtask
   // no debounce in the block, so a press is one clean level held past the sync chain
   task automatic press(input int idx);
      @(posedge clk_sys);
      {btn_menu, btn_inc, btn_dec} <= 3'h1 << idx;
      repeat (4) @(posedge clk_sys);
      {btn_menu, btn_inc, btn_dec} <= 3'h0;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
// testbench: self-checking scenarios for the gas alarm threshold logic
module tb
   import gatl_pkg::*;
;
   // ************************************************************
   // shortened timing so inhibit and idle fit a short run
   // ************************************************************
   localparam int TCK = 4;
   localparam int INH = 8;
   localparam int IDL = 12;
   localparam int T1 = THR1_RST_DEF;
   localparam int T2 = THR2_RST_DEF;
   logic clk_sys;
   logic rst_n;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic [15:0] conc;
   logic btn_menu, btn_inc, btn_dec;
   logic adapter_link_down, board_link_down, zero_fail, cal_fail;
   logic led_amber, led_red, relay1, relay2, fault_terminal;
   int err_total;
   int tests_run;
   logic ce;
   logic [31:0] d;
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   gatl_sensor_model gatl_sensor_model_i (.clk_sys(clk_sys), .conc(conc), .btn_menu(btn_menu),
      .btn_inc(btn_inc), .btn_dec(btn_dec), .adapter_link_down(adapter_link_down),
      .board_link_down(board_link_down), .zero_fail(zero_fail), .cal_fail(cal_fail));
   // ce drops in sc_freeze, where every flop must hold
   gatl_top #(.TICK_CYC_P(TCK), .INHIBIT_MS_P(INH), .IDLE_MS_P(IDL)) gatl_top_i (.clk_sys(clk_sys),
      .rst_n(rst_n), .ce(ce), .conc(conc), .btn_menu(btn_menu), .btn_inc(btn_inc), .btn_dec(btn_dec),
      .adapter_link_down(adapter_link_down), .board_link_down(board_link_down), .zero_fail(zero_fail),
      .cal_fail(cal_fail), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .led_amber(led_amber), .led_red(led_red), .relay1(relay1), .relay2(relay2),
      .fault_terminal(fault_terminal));
   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      reg_read(a, v);
      check(v, exp);
   endtask
   task automatic check_scr(input gatl_screen_t s);
      logic [31:0] v;
      reg_read(REG_STAT, v);
      check(32'(v[7:5]), 32'(s));
   endtask
   // bounded wait for the indicator pair; a timeout is reported and ends the run
   task automatic wait_led(input logic [1:0] exp);
      for (int i = 0; i < 100; i++) begin
         @(posedge clk_sys);
         #1;
         if ({led_red, led_amber} === exp) begin
            check(32'({led_red, led_amber}), 32'(exp));
            return;
         end
      end
      check(32'({led_red, led_amber}), 32'(exp));
      close_out();
   endtask
   task automatic hold(input logic [1:0] exp);
      repeat (6) @(posedge clk_sys);
      #1;
      check(32'({led_red, led_amber}), 32'(exp));
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic sc_reset();
      check(32'({led_red, led_amber, relay1, relay2, fault_terminal}), 32'h0);
      check_reg(REG_STAT, 32'h0);
      check_reg(REG_SET1, 32'(T1));
      check_reg(REG_SET2, 32'(T2));
      reg_write(REG_SET1, 32'h5);
      check_reg(REG_SET1, 32'(T1));
      check_reg(8'h40, 32'h0);
   endtask
   task automatic sc_faults();
      for (int i = 0; i < 4; i++) begin
         gatl_sensor_model_i.fault(i, 1'b1);
         repeat (4) @(posedge clk_sys);
         gatl_sensor_model_i.fault(i, 1'b0);
         repeat (4) @(posedge clk_sys);
         check_reg(REG_FAULT, 32'h1 << i);
         check(32'(fault_terminal), 32'h1);
         reg_write(REG_FAULT, 32'h1 << i);
         check_reg(REG_FAULT, 32'h0);
         check(32'(fault_terminal), 32'h0);
      end
      // a clear that meets a live failure must lose
      gatl_sensor_model_i.fault(FLT_CAL, 1'b1);
      reg_write(REG_FAULT, 32'h1 << FLT_CAL);
      gatl_sensor_model_i.fault(FLT_CAL, 1'b0);
      check_reg(REG_FAULT, 32'h1 << FLT_CAL);
      reg_write(REG_FAULT, 32'hF);
      check_reg(REG_FAULT, 32'h0);
   endtask
   // rising clears only below set-point minus a tenth of it
   task automatic sc_rising();
      gatl_sensor_model_i.set_conc(16'(T1));
      wait_led(2'h1);
      check(32'(relay1), 32'h0);
      reg_write(REG_CTRL, 32'h1 << CTRL_FIT);
      gatl_sensor_model_i.set_conc(16'h00FA);
      wait_led(2'h3);
      check(32'({relay2, relay1}), 32'h3);
      gatl_sensor_model_i.set_conc(16'(T2 - T2 * HYST_PCT / PCT_FULL));
      hold(2'h3);
      gatl_sensor_model_i.set_conc(16'(T2 - T2 * HYST_PCT / PCT_FULL - 1));
      wait_led(2'h1);
      gatl_sensor_model_i.set_conc(16'(T1 - T1 * HYST_PCT / PCT_FULL));
      hold(2'h1);
      gatl_sensor_model_i.set_conc(16'(T1 - T1 * HYST_PCT / PCT_FULL - 1));
      wait_led(2'h0);
      check(32'({relay2, relay1}), 32'h0);
   endtask
   task automatic sc_latch();
      reg_write(REG_CTRL, 32'h1 | (32'h1 << CTRL_FIT));
      check_reg(REG_CTRL, 32'h5);
      gatl_sensor_model_i.set_conc(16'h0096);
      wait_led(2'h1);
      check(32'(relay1), 32'h1);
      gatl_sensor_model_i.set_conc(16'h0000);
      hold(2'h1);
      gatl_sensor_model_i.set_conc(16'h0096);
      reg_write(REG_CMD, 32'h1);
      hold(2'h1);
      gatl_sensor_model_i.set_conc(16'h0000);
      wait_led(2'h0);
      reg_write(REG_CTRL, 32'h0);
   endtask
   // a low clock enable must hold every flop, alarms included
   task automatic sc_freeze();
      @(posedge clk_sys);
      ce <= 1'b0;
      gatl_sensor_model_i.set_conc(16'(T2));
      hold(2'h0);
      @(posedge clk_sys);
      ce <= 1'b1;
      wait_led(2'h3);
      gatl_sensor_model_i.set_conc(16'h0000);
      wait_led(2'h0);
   endtask
   // operator keeps the first set-point under the second: 102 against 199
   task automatic sc_menu();
      gatl_sensor_model_i.press(BTN_MENU);
      check_scr(SCR_THR1);
      gatl_sensor_model_i.press(BTN_INC);
      gatl_sensor_model_i.press(BTN_INC);
      gatl_sensor_model_i.press(BTN_MENU);
      check_scr(SCR_DIR1);
      check_reg(REG_SET1, 32'(T1 + 2));
      gatl_sensor_model_i.press(BTN_DEC);
      gatl_sensor_model_i.press(BTN_MENU);
      check_scr(SCR_THR2);
      gatl_sensor_model_i.press(BTN_DEC);
      gatl_sensor_model_i.press(BTN_MENU);
      check_scr(SCR_DIR2);
      check_reg(REG_SET2, 32'(T2 - 1));
      gatl_sensor_model_i.press(BTN_INC);
      gatl_sensor_model_i.press(BTN_MENU);
      // gas far above both set-points right after leaving the menu
      gatl_sensor_model_i.set_conc(16'h01F4);
      hold(2'h0);
      wait_led(2'h2);
      reg_read(REG_STAT, d);
      check(32'({d[7:5], d[3:2]}), 32'h1);
      gatl_sensor_model_i.set_conc(16'h0032);
      wait_led(2'h1);
      gatl_sensor_model_i.set_conc(16'(T1 + 2 + (T1 + 2) * HYST_PCT / PCT_FULL));
      hold(2'h1);
      gatl_sensor_model_i.set_conc(16'(T1 + 3 + (T1 + 2) * HYST_PCT / PCT_FULL));
      wait_led(2'h0);
   endtask
   task automatic sc_idle();
      gatl_sensor_model_i.press(BTN_MENU);
      check_scr(SCR_THR1);
      gatl_sensor_model_i.press(BTN_INC);
      for (int i = 0; i < 60; i++) begin
         reg_read(REG_STAT, d);
         if (d[7:5] === 3'h0) begin
            break;
         end
      end
      check(32'(d[7:4]), 32'h1);
      if (d[7:5] !== 3'h0) begin
         close_out();
      end
      check_reg(REG_SET1, 32'(T1 + 2));
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_total = 0;
      tests_run = 0;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      sc_reset();
      sc_faults();
      sc_rising();
      sc_latch();
      sc_freeze();
      sc_menu();
      sc_idle();
      close_out();
   end
endmodule
